// >>> hdl/dmm_top.sv
// Purpose: Dual micro-step motor control with Avalon-MM register port
// Assumes: One clock mclk at 125 MHz, synchronous active-high reset
// Notes: Two channels, test-signal monitor pins, registered outputs except waitrequest

`timescale 1ns/100ps
`default_nettype none

module dmm_top #(
	parameter int PWM_CYCLE = dmm_pkg::PWM_CYCLE_CYCLES
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic monitorPinFirst,
	output logic monitorPinSecond,
	output logic alphaDriveEnable,
	output logic [1:0] alphaHighOn,
	output logic [1:0] alphaLowOn,
	output logic betaDriveEnable,
	output logic [1:0] betaHighOn,
	output logic [1:0] betaLowOn
);

	logic ack_reg, wrStrobe, aligned;
	logic [5:0] wordIndex;
	logic testUnlockFirst_reg, testUnlockSecond_reg;
	logic [4:0] testSignalSelect_reg;
	logic [7:0] alphaStepCount_reg, betaStepCount_reg;
	logic alphaDirectionSelect_reg, alphaBrakeSelect_reg, alphaOutputEnable_reg;
	logic betaDirectionSelect_reg, betaBrakeSelect_reg, betaOutputEnable_reg;
	logic [1:0] alphaDivisionSelect_reg, betaDivisionSelect_reg;
	logic [15:0] alphaStepPeriod_reg, betaStepPeriod_reg;
	logic [31:0] merged, readValue;
	logic alphaCountLoad, betaCountLoad, alphaPeriodLoad, betaPeriodLoad;
	logic [7:0] alphaPosition, betaPosition;
	logic alphaRotating, betaRotating, alphaStartWait, betaStartWait;
	logic alphaExciteWait, betaExciteWait, alphaStepPulse, betaStepPulse;
	logic [15:0] pwmCount_reg;
	logic pwmLevel_reg, testActive, firstNext, secondNext, normalFirst, normalSecond;

	// ***************************************************
	// Avalon-MM slave: one wait cycle, then answer
	// ***************************************************
	assign waitrequest = (read || write) && !ack_reg;
	assign wrStrobe = write && ack_reg;
	assign aligned = (address[1:0] == 2'b00);
	assign wordIndex = address[7:2];

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (read || write) && !ack_reg;
		end
	end

	function automatic logic [31:0] mergeBytes(input logic [31:0] oldWord,
		input logic [31:0] newWord, input logic [3:0] lanes);
		logic [31:0] result;
		result = oldWord;
		for (int i = 0; i < 4; i++) begin
			if (lanes[i]) begin
				result[i*8 +: 8] = newWord[i*8 +: 8];
			end
		end
		return result;
	endfunction : mergeBytes

	always_comb begin
		readValue = 32'h00000000;
		if (aligned) begin
			case (wordIndex)
				dmm_pkg::IDX_TEST_UNLOCK_FIRST[5:0]: begin
					readValue[dmm_pkg::POS_UNLOCK] = testUnlockFirst_reg;
				end
				dmm_pkg::IDX_TEST_SIGNAL_SELECT[5:0]: begin
					readValue[dmm_pkg::POS_SELECT_LSB +: 5] = testSignalSelect_reg;
					readValue[dmm_pkg::POS_UNLOCK] = testUnlockSecond_reg;
				end
				dmm_pkg::IDX_ALPHA_CTRL[5:0]: begin
					readValue[dmm_pkg::POS_COUNT_LSB +: 8] = alphaStepCount_reg;
					readValue[dmm_pkg::POS_DIRECTION] = alphaDirectionSelect_reg;
					readValue[dmm_pkg::POS_BRAKE] = alphaBrakeSelect_reg;
					readValue[dmm_pkg::POS_ENABLE] = alphaOutputEnable_reg;
					readValue[dmm_pkg::POS_DIVISION_LSB +: 2] = alphaDivisionSelect_reg;
				end
				dmm_pkg::IDX_ALPHA_STEP_PERIOD[5:0]: begin
					readValue[15:0] = alphaStepPeriod_reg;
				end
				dmm_pkg::IDX_BETA_CTRL[5:0]: begin
					readValue[dmm_pkg::POS_COUNT_LSB +: 8] = betaStepCount_reg;
					readValue[dmm_pkg::POS_DIRECTION] = betaDirectionSelect_reg;
					readValue[dmm_pkg::POS_BRAKE] = betaBrakeSelect_reg;
					readValue[dmm_pkg::POS_ENABLE] = betaOutputEnable_reg;
					readValue[dmm_pkg::POS_DIVISION_LSB +: 2] = betaDivisionSelect_reg;
				end
				dmm_pkg::IDX_BETA_STEP_PERIOD[5:0]: begin
					readValue[15:0] = betaStepPeriod_reg;
				end
				dmm_pkg::IDX_STATUS[5:0]: begin
					readValue[dmm_pkg::POS_STAT_ALPHA_ROT] = alphaRotating;
					readValue[dmm_pkg::POS_STAT_BETA_ROT] = betaRotating;
					readValue[dmm_pkg::POS_STAT_ALPHA_POS +: 8] = alphaPosition;
					readValue[dmm_pkg::POS_STAT_BETA_POS +: 8] = betaPosition;
				end
				default: begin
					readValue = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			readdata <= 32'h00000000;
		end else if (read && !ack_reg) begin
			readdata <= readValue;
		end
	end

	// ***************************************************
	// Register writes
	// ***************************************************
	assign merged = mergeBytes(readValue, writedata, byteenable);
	assign alphaCountLoad = wrStrobe && aligned && (wordIndex == dmm_pkg::IDX_ALPHA_CTRL[5:0]);
	assign betaCountLoad = wrStrobe && aligned && (wordIndex == dmm_pkg::IDX_BETA_CTRL[5:0]);
	assign alphaPeriodLoad = wrStrobe && aligned
		&& (wordIndex == dmm_pkg::IDX_ALPHA_STEP_PERIOD[5:0]);
	assign betaPeriodLoad = wrStrobe && aligned
		&& (wordIndex == dmm_pkg::IDX_BETA_STEP_PERIOD[5:0]);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			testUnlockFirst_reg <= 1'b0;
			testUnlockSecond_reg <= 1'b0;
			testSignalSelect_reg <= dmm_pkg::RST_SELECT;
		end else if (wrStrobe && aligned) begin
			if (wordIndex == dmm_pkg::IDX_TEST_UNLOCK_FIRST[5:0]) begin
				testUnlockFirst_reg <= merged[dmm_pkg::POS_UNLOCK];
			end
			if (wordIndex == dmm_pkg::IDX_TEST_SIGNAL_SELECT[5:0]) begin
				testUnlockSecond_reg <= merged[dmm_pkg::POS_UNLOCK];
				testSignalSelect_reg <= merged[dmm_pkg::POS_SELECT_LSB +: 5];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			alphaStepCount_reg <= 8'h00;
			alphaDirectionSelect_reg <= 1'b0;
			alphaBrakeSelect_reg <= 1'b0;
			alphaOutputEnable_reg <= 1'b0;
			alphaDivisionSelect_reg <= dmm_pkg::RST_DIVISION;
		end else if (alphaCountLoad) begin
			alphaStepCount_reg <= merged[dmm_pkg::POS_COUNT_LSB +: 8];
			alphaDirectionSelect_reg <= merged[dmm_pkg::POS_DIRECTION];
			alphaBrakeSelect_reg <= merged[dmm_pkg::POS_BRAKE];
			alphaOutputEnable_reg <= merged[dmm_pkg::POS_ENABLE];
			alphaDivisionSelect_reg <= merged[dmm_pkg::POS_DIVISION_LSB +: 2];
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			betaStepCount_reg <= 8'h00;
			betaDirectionSelect_reg <= 1'b0;
			betaBrakeSelect_reg <= 1'b0;
			betaOutputEnable_reg <= 1'b0;
			betaDivisionSelect_reg <= dmm_pkg::RST_DIVISION;
		end else if (betaCountLoad) begin
			betaStepCount_reg <= merged[dmm_pkg::POS_COUNT_LSB +: 8];
			betaDirectionSelect_reg <= merged[dmm_pkg::POS_DIRECTION];
			betaBrakeSelect_reg <= merged[dmm_pkg::POS_BRAKE];
			betaOutputEnable_reg <= merged[dmm_pkg::POS_ENABLE];
			betaDivisionSelect_reg <= merged[dmm_pkg::POS_DIVISION_LSB +: 2];
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			alphaStepPeriod_reg <= dmm_pkg::RST_STEP_PERIOD;
			betaStepPeriod_reg <= dmm_pkg::RST_STEP_PERIOD;
		end else begin
			if (alphaPeriodLoad) begin
				alphaStepPeriod_reg <= merged[15:0];
			end
			if (betaPeriodLoad) begin
				betaStepPeriod_reg <= merged[15:0];
			end
		end
	end

	// ***************************************************
	// Motor channels
	// ***************************************************
	dmm_channel alphaChannel (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.stepPeriod(alphaStepPeriod_reg),
		.divisionSelect(alphaDivisionSelect_reg),
		.directionSelect(alphaDirectionSelect_reg),
		.brakeSelect(alphaBrakeSelect_reg),
		.outputEnable(alphaOutputEnable_reg),
		.countLoad(alphaCountLoad),
		.periodLoad(alphaPeriodLoad),
		.stepCount(merged[dmm_pkg::POS_COUNT_LSB +: 8]),
		.position(alphaPosition),
		.rotating(alphaRotating),
		.startWait(alphaStartWait),
		.exciteWait(alphaExciteWait),
		.stepPulse(alphaStepPulse),
		.driveEnable(alphaDriveEnable),
		.highOn(alphaHighOn),
		.lowOn(alphaLowOn)
	);

	dmm_channel betaChannel (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.stepPeriod(betaStepPeriod_reg),
		.divisionSelect(betaDivisionSelect_reg),
		.directionSelect(betaDirectionSelect_reg),
		.brakeSelect(betaBrakeSelect_reg),
		.outputEnable(betaOutputEnable_reg),
		.countLoad(betaCountLoad),
		.periodLoad(betaPeriodLoad),
		.stepCount(merged[dmm_pkg::POS_COUNT_LSB +: 8]),
		.position(betaPosition),
		.rotating(betaRotating),
		.startWait(betaStartWait),
		.exciteWait(betaExciteWait),
		.stepPulse(betaStepPulse),
		.driveEnable(betaDriveEnable),
		.highOn(betaHighOn),
		.lowOn(betaLowOn)
	);

	// ***************************************************
	// PWM cycle monitor divider
	// ***************************************************
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pwmCount_reg <= 16'h0000;
			pwmLevel_reg <= 1'b0;
		end else if (pwmCount_reg == 16'(PWM_CYCLE / 2 - 1)) begin
			pwmCount_reg <= 16'h0000;
			pwmLevel_reg <= !pwmLevel_reg;
		end else begin
			pwmCount_reg <= pwmCount_reg + 16'h0001;
		end
	end

	// ***************************************************
	// Monitor pin selection
	// ***************************************************
	assign testActive = testUnlockFirst_reg && testUnlockSecond_reg;
	assign normalFirst = alphaStepPulse;
	assign normalSecond = betaStepPulse;

	always_comb begin
		firstNext = normalFirst;
		secondNext = normalSecond;
		if (testActive) begin
			case (testSignalSelect_reg)
				dmm_pkg::DMM_TS_START_WAIT: begin
					firstNext = alphaStartWait || betaStartWait;
					secondNext = 1'b0;
				end
				dmm_pkg::DMM_TS_EXCITE_WAIT: begin
					firstNext = alphaExciteWait;
					secondNext = betaExciteWait;
				end
				dmm_pkg::DMM_TS_ENABLE: begin
					firstNext = alphaOutputEnable_reg;
					secondNext = betaOutputEnable_reg;
				end
				dmm_pkg::DMM_TS_DIRECTION: begin
					firstNext = alphaDirectionSelect_reg;
					secondNext = betaDirectionSelect_reg;
				end
				dmm_pkg::DMM_TS_PULSE_MON: begin
					firstNext = alphaPosition[2];
					secondNext = betaPosition[2];
				end
				dmm_pkg::DMM_TS_PWM_CYCLE: begin
					firstNext = pwmLevel_reg;
					secondNext = 1'b0;
				end
				dmm_pkg::DMM_TS_COMPLETION: begin
					firstNext = alphaRotating;
					secondNext = betaRotating;
				end
				default: begin
					firstNext = normalFirst;
					secondNext = normalSecond;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			monitorPinFirst <= 1'b0;
			monitorPinSecond <= 1'b0;
		end else begin
			monitorPinFirst <= firstNext;
			monitorPinSecond <= secondNext;
		end
	end

	// ***************************************************
	// Checks
	// ***************************************************
	chk_test_gate_off: assert property (@(posedge mclk) disable iff (sys_rst)
		!testActive |=> (monitorPinFirst == $past(alphaStepPulse)
		&& monitorPinSecond == $past(betaStepPulse)))
		else $error("test signal leaked without unlock");
	chk_code_normal: assert property (@(posedge mclk) disable iff (sys_rst)
		(testActive && testSignalSelect_reg == 5'h00) |=> monitorPinFirst == $past(alphaStepPulse))
		else $error("code zero not normal");
	chk_code_enable: assert property (@(posedge mclk) disable iff (sys_rst)
		(testActive && testSignalSelect_reg == 5'h03)
		|=> monitorPinSecond == $past(betaOutputEnable_reg))
		else $error("enable monitor wrong");
	chk_code_pwm: assert property (@(posedge mclk) disable iff (sys_rst)
		(testActive && testSignalSelect_reg == 5'h06) |=> !monitorPinSecond)
		else $error("second pin not low in PWM code");
	chk_code_rotate: assert property (@(posedge mclk) disable iff (sys_rst)
		(testActive && testSignalSelect_reg == 5'h07) |=> monitorPinFirst == $past(alphaRotating))
		else $error("completion monitor wrong");

endmodule : dmm_top

`default_nettype wire

// >>> hdl/dmm_pkg.sv
// Purpose: Shared constants for the dual micro-step motor control block
// Assumes: 32-bit Avalon-MM register port, word index times four is byte address
// Notes: Field positions inside each register word, reset values, timing counts

package dmm_pkg;

	// ***************************************************
	// Register indices (byte address is index times four)
	// ***************************************************
	localparam logic [7:0] IDX_TEST_UNLOCK_FIRST = 8'h0B;
	localparam logic [7:0] IDX_TEST_SIGNAL_SELECT = 8'h21;
	localparam logic [7:0] IDX_ALPHA_CTRL = 8'h24;
	localparam logic [7:0] IDX_ALPHA_STEP_PERIOD = 8'h25;
	localparam logic [7:0] IDX_BETA_CTRL = 8'h29;
	localparam logic [7:0] IDX_BETA_STEP_PERIOD = 8'h2A;
	localparam logic [7:0] IDX_STATUS = 8'h30;

	// ***************************************************
	// Field positions
	// ***************************************************
	localparam int POS_UNLOCK = 7;
	localparam int POS_SELECT_LSB = 0;
	localparam int POS_COUNT_LSB = 0;
	localparam int POS_DIRECTION = 8;
	localparam int POS_BRAKE = 9;
	localparam int POS_ENABLE = 10;
	localparam int POS_DIVISION_LSB = 12;
	localparam int POS_STAT_ALPHA_ROT = 0;
	localparam int POS_STAT_BETA_ROT = 1;
	localparam int POS_STAT_ALPHA_POS = 8;
	localparam int POS_STAT_BETA_POS = 16;

	// ***************************************************
	// Reset values
	// ***************************************************
	localparam logic [4:0] RST_SELECT = 5'h00;
	localparam logic [15:0] RST_STEP_PERIOD = 16'h0080;
	localparam logic [1:0] RST_DIVISION = 2'h0;

	// ***************************************************
	// Division codes and timing multipliers
	// ***************************************************
	localparam logic [1:0] DIV_CODE_128 = 2'h2;
	localparam logic [1:0] DIV_CODE_64 = 2'h3;
	localparam logic [3:0] CYCLES_PER_N_64 = 4'hC;
	localparam logic [3:0] CYCLES_PER_N_128 = 4'h6;
	localparam logic [3:0] CYCLES_PER_N_256 = 4'h3;
	localparam logic [2:0] ADVANCE_64 = 3'h4;
	localparam logic [2:0] ADVANCE_128 = 3'h2;
	localparam logic [2:0] ADVANCE_256 = 3'h1;
	localparam int PWM_CYCLE_CYCLES = 240;

	// ***************************************************
	// Test signal codes
	// ***************************************************
	typedef enum logic [4:0] {
		DMM_TS_NORMAL = 5'h00,
		DMM_TS_START_WAIT = 5'h01,
		DMM_TS_EXCITE_WAIT = 5'h02,
		DMM_TS_ENABLE = 5'h03,
		DMM_TS_DIRECTION = 5'h04,
		DMM_TS_PULSE_MON = 5'h05,
		DMM_TS_PWM_CYCLE = 5'h06,
		DMM_TS_COMPLETION = 5'h07
	} dmm_test_type;

endpackage : dmm_pkg

// >>> hdl/dmm_channel.sv
// Purpose: One motor channel: step timer, position counter, bridge control
// Assumes: Inputs synchronous to mclk, load strobes one cycle wide
// Notes: Position counter runs whatever the output enable says

`timescale 1ns/100ps
`default_nettype none

module dmm_channel (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [15:0] stepPeriod,
	input wire logic [1:0] divisionSelect,
	input wire logic directionSelect,
	input wire logic brakeSelect,
	input wire logic outputEnable,
	input wire logic countLoad,
	input wire logic periodLoad,
	input wire logic [7:0] stepCount,
	output logic [7:0] position,
	output logic rotating,
	output logic startWait,
	output logic exciteWait,
	output logic stepPulse,
	output logic driveEnable,
	output logic [1:0] highOn,
	output logic [1:0] lowOn
);

	logic [19:0] targetCycles;
	logic [19:0] timer_reg;
	logic [10:0] remaining_reg;
	logic [7:0] position_reg;
	logic [2:0] advance;
	logic [3:0] cyclesPerN;
	logic firstStepDone_reg;
	logic cfgChange;
	logic [19:0] gapCount_reg;
	logic gapValid_reg;

	// ***************************************************
	// Step timing
	// ***************************************************
	always_comb begin
		case (divisionSelect)
			dmm_pkg::DIV_CODE_64: begin
				cyclesPerN = dmm_pkg::CYCLES_PER_N_64;
				advance = dmm_pkg::ADVANCE_64;
			end
			dmm_pkg::DIV_CODE_128: begin
				cyclesPerN = dmm_pkg::CYCLES_PER_N_128;
				advance = dmm_pkg::ADVANCE_128;
			end
			default: begin
				cyclesPerN = dmm_pkg::CYCLES_PER_N_256;
				advance = dmm_pkg::ADVANCE_256;
			end
		endcase
	end

	assign targetCycles = {4'h0, stepPeriod} * {16'h0000, cyclesPerN};
	assign cfgChange = countLoad | periodLoad;
	assign rotating = (remaining_reg != 11'h000) && (stepPeriod != 16'h0000);
	assign stepPulse = rotating && !cfgChange && (timer_reg == targetCycles - 20'h00001);
	assign position = position_reg;
	assign startWait = (remaining_reg != 11'h000) && (stepPeriod == 16'h0000);
	assign exciteWait = rotating && !firstStepDone_reg;

	always_ff @(posedge mclk) begin
		if (sys_rst || cfgChange || !rotating || stepPulse) begin
			timer_reg <= 20'h00000;
		end else begin
			timer_reg <= timer_reg + 20'h00001;
		end
	end

	// ***************************************************
	// Remaining travel in 256-division units
	// ***************************************************
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			remaining_reg <= 11'h000;
		end else if (countLoad) begin
			remaining_reg <= {stepCount, 3'h0};
		end else if (stepPulse) begin
			if (remaining_reg <= {8'h00, advance}) begin
				remaining_reg <= 11'h000;
			end else begin
				remaining_reg <= remaining_reg - {8'h00, advance};
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || countLoad) begin
			firstStepDone_reg <= 1'b0;
		end else if (stepPulse) begin
			firstStepDone_reg <= 1'b1;
		end
	end

	// ***************************************************
	// Excitation position, advances even when disabled
	// ***************************************************
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			position_reg <= 8'h00;
		end else if (stepPulse) begin
			if (directionSelect) begin
				position_reg <= position_reg - {5'h00, advance};
			end else begin
				position_reg <= position_reg + {5'h00, advance};
			end
		end
	end

	// ***************************************************
	// Output bridge
	// ***************************************************
	always_ff @(posedge mclk) begin
		if (sys_rst || !outputEnable) begin
			driveEnable <= 1'b0;
			highOn <= 2'b00;
			lowOn <= 2'b00;
		end else if (brakeSelect) begin
			driveEnable <= 1'b1;
			highOn <= 2'b11;
			lowOn <= 2'b00;
		end else begin
			driveEnable <= 1'b1;
			highOn <= position_reg[7] ? 2'b10 : 2'b01;
			lowOn <= position_reg[7] ? 2'b01 : 2'b10;
		end
	end

	// ***************************************************
	// Checks
	// ***************************************************
	always_ff @(posedge mclk) begin
		if (sys_rst || cfgChange) begin
			gapValid_reg <= 1'b0;
			gapCount_reg <= 20'h00000;
		end else if (stepPulse) begin
			gapValid_reg <= 1'b1;
			gapCount_reg <= 20'h00001;
		end else if (gapCount_reg != 20'hFFFFF) begin
			gapCount_reg <= gapCount_reg + 20'h00001;
		end
	end

	chk_brake_highs: assert property (@(posedge mclk) disable iff (sys_rst)
		(brakeSelect && outputEnable) |=> (highOn == 2'b11 && lowOn == 2'b00))
		else $error("brake did not turn on both high sides");
	chk_disable_hiz: assert property (@(posedge mclk) disable iff (sys_rst)
		!outputEnable |=> (!driveEnable && highOn == 2'b00 && lowOn == 2'b00))
		else $error("disabled channel still drives");
	chk_pos_moves_off: assert property (@(posedge mclk) disable iff (sys_rst)
		(stepPulse && !outputEnable) |=> position_reg != $past(position_reg))
		else $error("position froze while disabled");
	chk_step_advance: assert property (@(posedge mclk) disable iff (sys_rst)
		(stepPulse && !directionSelect) |=> position_reg == $past(position_reg) + $past(advance))
		else $error("wrong advance for division");
	chk_step_spacing: assert property (@(posedge mclk) disable iff (sys_rst)
		(stepPulse && gapValid_reg) |-> gapCount_reg == targetCycles)
		else $error("step period wrong");
	chk_zero_halts: assert property (@(posedge mclk) disable iff (sys_rst)
		(stepPeriod == 16'h0000) |-> !stepPulse [*2])
		else $error("stepping with zero period");

endmodule : dmm_channel

`default_nettype wire

// >>> testbench/dmm_coil_model.sv
// Purpose: Coil pair behind one H-bridge
// Assumes: Bridge controls are registered on mclk
// Notes: State 0 open, 1 forward, 2 reverse, 3 brake
`timescale 1ns/100ps
`default_nettype none
module dmm_coil_model (
	input wire logic driveEnable,
	input wire logic [1:0] highOn,
	input wire logic [1:0] lowOn,
	output logic [1:0] coilState
);
	always_comb begin
		if (!driveEnable) coilState = 2'h0;
		else if (highOn == 2'h3 && lowOn == 2'h0) coilState = 2'h3;
		else if (highOn == 2'h1 && lowOn == 2'h2) coilState = 2'h1;
		else if (highOn == 2'h2 && lowOn == 2'h1) coilState = 2'h2;
		else coilState = 2'h0;
	end
endmodule : dmm_coil_model
`default_nettype wire

// >>> testbench/dmm_top_tb.sv
// Purpose: Self-checking bench for the motor control block
// Assumes: Avalon master waits for waitrequest low
// Notes: Pin word is pin1, pin2, alpha coil, beta coil
`timescale 1ns/100ps
`default_nettype none
module dmm_top_tb;
	logic mclk = 1'b0;
	logic sysRst = 1'b1;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic pin1;
	logic pin2;
	logic pinReq = 1'b0;
	logic aEn;
	logic bEn;
	logic [1:0] aHi, aLo, bHi, bLo, aState, bState;
	logic [15:0] rnd;
	logic [31:0] expQ[$];
	string nameQ[$];
	int badCount = 0;
	int checkCount = 0;
	int cyc = 0;
	localparam int PWM = 8;
	initial forever #4 mclk = ~mclk;
	dmm_top #(.PWM_CYCLE(PWM)) DUT (.mclk(mclk), .sys_rst(sysRst), .address(address),
		.read(read), .write(write), .byteenable(4'hF), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .monitorPinFirst(pin1),
		.monitorPinSecond(pin2), .alphaDriveEnable(aEn), .alphaHighOn(aHi),
		.alphaLowOn(aLo), .betaDriveEnable(bEn), .betaHighOn(bHi), .betaLowOn(bLo));
	dmm_coil_model alphaCoil (.driveEnable(aEn), .highOn(aHi), .lowOn(aLo), .coilState(aState));
	dmm_coil_model betaCoil (.driveEnable(bEn), .highOn(bHi), .lowOn(bLo), .coilState(bState));
	// ****************
	// Tasks
	// ****************
	task automatic conclude();
		$display("checks %0d mismatches %0d", checkCount, badCount);
		if (badCount == 0 && checkCount > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	task automatic compare(input string name, input logic [31:0] e, input logic [31:0] got);
		checkCount++;
		if (got !== e) begin
			badCount++;
			$display("ERROR %s expected %h seen %h", name, e, got);
		end
	endtask : compare
	task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do @(posedge mclk); while (waitrequest !== 1'b0);
		write <= 1'b0;
		read <= 1'b0;
	endtask : acc
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expQ.push_back(e);
		nameQ.push_back($sformatf("register %h", a));
		acc(1'b0, a, 32'h0);
	endtask : rd
	task automatic pin(input logic [31:0] e);
		repeat (2) @(posedge mclk);
		expQ.push_back(e);
		nameQ.push_back("pins");
		pinReq <= 1'b1;
		@(posedge mclk);
		pinReq <= 1'b0;
	endtask : pin
	// ****************
	// Checking
	// ****************
	always @(posedge mclk) begin
		if (read && waitrequest === 1'b0) compare(nameQ.pop_front(), expQ.pop_front(), readdata);
		if (pinReq) compare(nameQ.pop_front(), expQ.pop_front(), {26'h0, pin1, pin2, aState, bState});
	end
	always @(posedge mclk) cyc <= sysRst ? 0 : cyc + 1;
	initial begin
		repeat (4000) @(posedge mclk);
		badCount++;
		conclude();
	end
	// ****************
	// Stimulus
	// ****************
	initial begin
		void'($urandom(71));
		repeat (6) @(posedge mclk);
		sysRst <= 1'b0;
		rd(8'h94, 32'h80);
		rd(8'hA8, 32'h80);
		rd(8'h90, 32'h0);
		rd(8'h84, 32'h0);
		rd(8'hFC, 32'h0);
		pin(32'h0);
		$display("test reset done");
		acc(1'b1, 8'h90, 32'h400);
		pin(32'h4);
		acc(1'b1, 8'h90, 32'h600);
		pin(32'hC);
		acc(1'b1, 8'h90, 32'h200);
		pin(32'h0);
		acc(1'b1, 8'hA4, 32'h600);
		pin(32'h3);
		$display("test bridge done");
		acc(1'b1, 8'h90, 32'h500);
		acc(1'b1, 8'hA4, 32'h100);
		acc(1'b1, 8'h84, 32'h83);
		pin(32'h4);
		acc(1'b1, 8'h2C, 32'h80);
		pin(32'h24);
		acc(1'b1, 8'h84, 32'h84);
		pin(32'h34);
		acc(1'b1, 8'h84, 32'h80);
		pin(32'h4);
		$display("test monitor done");
		rnd = 16'($urandom);
		acc(1'b1, 8'h94, {16'h0, rnd});
		rd(8'h94, {16'h0, rnd});
		acc(1'b1, 8'h94, 32'h4);
		acc(1'b1, 8'h84, 32'h87);
		for (int c = 0; c < 4; c++) begin
			acc(1'b1, 8'h90, 32'(c << 12) | 32'h1);
			repeat (75) @(posedge mclk);
			pin(32'h20);
			repeat (30) @(posedge mclk);
			rd(8'hC0, 32'(8 * (c + 1)) << 8);
		end
		$display("test division done");
		acc(1'b1, 8'h94, 32'h0);
		acc(1'b1, 8'h84, 32'h81);
		acc(1'b1, 8'h90, 32'h3401);
		pin(32'h24);
		rd(8'hC0, 32'h2000);
		$display("test hold done");
		acc(1'b1, 8'h84, 32'h82);
		acc(1'b1, 8'h94, 32'h4);
		pin(32'h24);
		acc(1'b1, 8'h84, 32'h85);
		repeat (55) @(posedge mclk);
		pin(32'h24);
		repeat (40) @(posedge mclk);
		pin(32'h4);
		rd(8'hC0, 32'h2800);
		acc(1'b1, 8'h84, 32'h86);
		for (int k = 0; k < 4; k++) pin((32'(((cyc + 2) / (PWM / 2)) % 2) << 5) | 32'h4);
		$display("test pulse done");
		conclude();
	end
endmodule : dmm_top_tb
`default_nettype wire
